// File: logic/rcg_pkg.sv
// shared constants and types for the relay channel guard sequencer
// Function
// - Blocked channels are held in a list and never close.
// - Entries give slot and channel, matrix entries add a row; several entries combine.
// - A range entry blocks every channel from first through last.
// - A memory reference entry blocks every channel of that stored pattern.
// - An empty list cancels blocking; no channel stays blocked.
// - Blocking a channel used by scan list or pattern clears that list or pattern.
// - Open-before-close setting takes 0 (off) or 1 (on).
// - Open-before-close query answers 1 when on, 0 when off.
// - With open-before-close on, closed channels open fully before the next closes.
// - With open-before-close off, opening and closing may overlap.
// - One-closed-at-a-time setting takes 0 (off) or 1 (on).
// - In one-closed mode a close opens the previous channel; one closed at most.
// - Turning one-closed mode on opens every channel.
// - Power-up restores the saved blocked list; reset and preset leave it alone.
package rcg_pkg;

    // ------------------------------------------------------------------
    // channel geometry
    // ------------------------------------------------------------------
    localparam int NUM_SLOT = 2;
    localparam int SLOT_CH = 40;
    localparam int MTX_COLS = 10;
    localparam int NUM_CH = NUM_SLOT * SLOT_CH;
    localparam int CH_W = 7;
    localparam int NUM_PAT = 100;
    localparam int PAT_W = 7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int RELAY_BREAK_NS = 1000;
    localparam int BREAK_CYC = (RELAY_BREAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------------
    // reset values of the settings (reset and preset: open-before-close on)
    // ------------------------------------------------------------------
    localparam logic OBC_RST = 1'b1;
    localparam logic ONE_RST = 1'b0;

    // ------------------------------------------------------------------
    // decoded host commands
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_BLOCK_ADD  = 4'h0,
        OP_BLOCK_PAT  = 4'h1,
        OP_BLOCK_CLR  = 4'h2,
        OP_OBC_SET    = 4'h3,
        OP_OBC_QRY    = 4'h4,
        OP_ONE_SET    = 4'h5,
        OP_ONE_QRY    = 4'h6,
        OP_CLOSE      = 4'h7,
        OP_OPEN       = 4'h8,
        OP_OPEN_ALL   = 4'h9,
        OP_RECALL     = 4'hA,
        OP_PAT_STORE  = 4'hB,
        OP_SCAN_ADD   = 4'hC,
        OP_SCAN_CLR   = 4'hD,
        OP_RESET      = 4'hE,
        OP_NOP        = 4'hF
    } rcg_op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BREAK = 2'b01
    } rcg_state_e;

endpackage : rcg_pkg

// File: logic/rcg_chan_mask.sv
// channel mask covering every index from a first through a last channel
module rcg_chan_mask
    import rcg_pkg::*;
#(
    parameter int N = NUM_CH
) (
    // range ends
    input wire logic [CH_W-1:0] lo_i,
    input wire logic [CH_W-1:0] hi_i,
    input wire logic en_i,
    // result
    output logic [N-1:0] mask_o
);

    // ------------------------------------------------------------------
    // per-channel compare
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_bit
            localparam logic [CH_W-1:0] IDX = CH_W'(gi);
            assign mask_o[gi] = en_i && (IDX >= lo_i) && (IDX <= hi_i);
        end
    endgenerate

endmodule : rcg_chan_mask

// File: logic/rcg_guard_seq.sv
// relay channel guard and close sequencer top
module rcg_guard_seq
    import rcg_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // decoded command
    input wire logic cmd_valid_i,
    input wire rcg_op_e cmd_op_i,
    input wire logic cmd_matrix_i,
    input wire logic [1:0] a_slot_i,
    input wire logic [2:0] a_row_i,
    input wire logic [5:0] a_col_i,
    input wire logic cmd_range_i,
    input wire logic [1:0] b_slot_i,
    input wire logic [2:0] b_row_i,
    input wire logic [5:0] b_col_i,
    input wire logic [PAT_W-1:0] cmd_pat_i,
    input wire logic cmd_bool_i,
    // saved blocked list
    input wire logic [NUM_CH-1:0] nv_list_i,
    // answers
    output logic cmd_ready_o,
    output logic resp_valid_o,
    output logic resp_data_o,
    output logic err_o,
    // state
    output logic [NUM_CH-1:0] relay_closed_o,
    output logic [NUM_CH-1:0] blocked_list_o,
    output logic [NUM_CH-1:0] scan_list_o,
    output logic obc_o,
    output logic one_closed_o
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] closed_reg, blocked_reg, scan_reg, target_reg;
    logic [NUM_CH-1:0] pat_mem [NUM_PAT];
    logic obc_reg, one_reg, restored_reg, ready_reg;
    logic resp_valid_reg, resp_data_reg, err_reg;
    rcg_state_e state_reg;
    logic [CNT_W-1:0] cnt_reg;

    // ------------------------------------------------------------------
    // entry decode
    // ------------------------------------------------------------------
    function automatic logic [CH_W-1:0] chan_idx(input logic mtx, input logic [1:0] slot,
                                                 input logic [2:0] row, input logic [5:0] col);
        logic [CH_W+3:0] v;
        v = (CH_W + 4)'(slot - 2'h1) * (CH_W + 4)'(SLOT_CH);
        if (mtx) begin
            v = v + (CH_W + 4)'(row - 3'h1) * (CH_W + 4)'(MTX_COLS) + (CH_W + 4)'(col - 6'h1);
        end else begin
            v = v + (CH_W + 4)'(col - 6'h1);
        end
        return v[CH_W-1:0];
    endfunction : chan_idx

    logic take;
    logic [CH_W-1:0] lo_idx, hi_idx;
    logic [NUM_CH-1:0] range_mask, pat_sel, one_hot, target_next, recall_all, recall_one;
    logic ch_blocked;

    assign take = cmd_valid_i && ready_reg;
    assign lo_idx = chan_idx(cmd_matrix_i, a_slot_i, a_row_i, a_col_i);
    assign hi_idx = cmd_range_i ? chan_idx(cmd_matrix_i, b_slot_i, b_row_i, b_col_i) : lo_idx;
    assign pat_sel = (32'(cmd_pat_i) < NUM_PAT) ? pat_mem[cmd_pat_i] : '0;
    assign one_hot = range_mask & ~(range_mask - NUM_CH'(1)); // lowest bit only
    assign ch_blocked = |(one_hot & blocked_reg);
    assign recall_all = pat_sel & ~blocked_reg;
    assign recall_one = recall_all & ~(recall_all - NUM_CH'(1));

    rcg_chan_mask #(
        .N(NUM_CH)
    ) u_mask (
        .lo_i(lo_idx),
        .hi_i(hi_idx),
        .en_i(cmd_valid_i),
        .mask_o(range_mask)
    );

    // ------------------------------------------------------------------
    // blocked list and power-up restore
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] add_mask;
    logic add_now;
    assign add_now = take && (cmd_op_i == OP_BLOCK_ADD || cmd_op_i == OP_BLOCK_PAT);
    assign add_mask = (cmd_op_i == OP_BLOCK_PAT) ? pat_sel : range_mask;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blocked_reg <= '0;
            restored_reg <= 1'b0;
        end else if (!restored_reg) begin
            blocked_reg <= nv_list_i;
            restored_reg <= 1'b1;
        end else if (take && cmd_op_i == OP_BLOCK_CLR) begin
            blocked_reg <= '0;
        end else if (add_now) begin
            blocked_reg <= blocked_reg | add_mask;
        end
    end

    // ------------------------------------------------------------------
    // scan list and stored patterns
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_reg <= '0;
        end else if (add_now && |(add_mask & scan_reg)) begin
            scan_reg <= '0;
        end else if (take && cmd_op_i == OP_SCAN_CLR) begin
            scan_reg <= '0;
        end else if (take && cmd_op_i == OP_SCAN_ADD) begin
            scan_reg <= scan_reg | (range_mask & ~blocked_reg);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_PAT; i++) begin
                pat_mem[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_PAT; i++) begin
                if (add_now && |(add_mask & pat_mem[i])) begin
                    pat_mem[i] <= '0;
                end else if (take && cmd_op_i == OP_PAT_STORE && 32'(cmd_pat_i) == i) begin
                    pat_mem[i] <= closed_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // settings and query answers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            obc_reg <= OBC_RST;
            one_reg <= ONE_RST;
        end else if (take && cmd_op_i == OP_RESET) begin
            obc_reg <= OBC_RST;
            one_reg <= ONE_RST;
        end else if (take && cmd_op_i == OP_OBC_SET) begin
            obc_reg <= cmd_bool_i;
        end else if (take && cmd_op_i == OP_ONE_SET) begin
            one_reg <= cmd_bool_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resp_valid_reg <= 1'b0;
            resp_data_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            resp_valid_reg <= take && (cmd_op_i == OP_OBC_QRY || cmd_op_i == OP_ONE_QRY);
            resp_data_reg <= (cmd_op_i == OP_OBC_QRY) ? obc_reg : one_reg;
            err_reg <= take && cmd_op_i == OP_CLOSE && ch_blocked;
        end
    end

    // ------------------------------------------------------------------
    // close sequencer
    // ------------------------------------------------------------------
    logic seq_now;
    always_comb begin
        target_next = closed_reg;
        seq_now = 1'b0;
        if (take) begin
            unique case (cmd_op_i)
                OP_CLOSE: begin
                    seq_now = !ch_blocked;
                    target_next = one_reg ? one_hot : (closed_reg | one_hot);
                end
                OP_OPEN: begin
                    seq_now = 1'b1;
                    target_next = closed_reg & ~range_mask;
                end
                OP_RECALL: begin
                    seq_now = 1'b1;
                    target_next = one_reg ? recall_one : recall_all;
                end
                default: begin
                    seq_now = 1'b0;
                    target_next = closed_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            closed_reg <= '0;
            target_reg <= '0;
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    ready_reg <= restored_reg;
                    if (take && (cmd_op_i == OP_OPEN_ALL || cmd_op_i == OP_RESET)) begin
                        closed_reg <= '0;
                    end else if (take && cmd_op_i == OP_ONE_SET && cmd_bool_i && !one_reg) begin
                        closed_reg <= '0;
                    end else if (add_now) begin
                        closed_reg <= closed_reg & ~add_mask;
                    end else if (seq_now && obc_reg && |(closed_reg & ~target_next)
                                 && |(target_next & ~closed_reg)) begin
                        closed_reg <= closed_reg & target_next;
                        target_reg <= target_next;
                        cnt_reg <= CNT_W'(BREAK_CYC - 1);
                        state_reg <= ST_BREAK;
                        ready_reg <= 1'b0;
                    end else if (seq_now) begin
                        closed_reg <= target_next;
                    end
                end
                ST_BREAK: begin
                    if (cnt_reg == '0) begin
                        closed_reg <= target_reg;
                        state_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign cmd_ready_o = ready_reg;
    assign resp_valid_o = resp_valid_reg;
    assign resp_data_o = resp_data_reg;
    assign err_o = err_reg;
    assign relay_closed_o = closed_reg;
    assign blocked_list_o = blocked_reg;
    assign scan_list_o = scan_reg;
    assign obc_o = obc_reg;
    assign one_closed_o = one_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_no_blocked_closed;
        @(posedge clock_i) disable iff (!rst_n_i) (closed_reg & blocked_reg) == '0;
    endproperty
    a_no_blocked_closed: assert property (p_no_blocked_closed) else $error("blocked closed");

    property p_range_block;
        @(posedge clock_i) disable iff (!rst_n_i)
            (take && cmd_op_i == OP_BLOCK_ADD) |=> ((blocked_reg & $past(range_mask))
                                                    == $past(range_mask));
    endproperty
    a_range_block: assert property (p_range_block) else $error("range not blocked");

    property p_clear_list;
        @(posedge clock_i) disable iff (!rst_n_i)
            (restored_reg && take && cmd_op_i == OP_BLOCK_CLR) |=> blocked_reg == '0;
    endproperty
    a_clear_list: assert property (p_clear_list) else $error("list not cancelled");

    property p_scan_clear;
        @(posedge clock_i) disable iff (!rst_n_i)
            (add_now && |(add_mask & scan_reg)) |=> scan_reg == '0;
    endproperty
    a_scan_clear: assert property (p_scan_clear) else $error("scan list kept");

    property p_obc_query;
        @(posedge clock_i) disable iff (!rst_n_i)
            (take && cmd_op_i == OP_OBC_QRY) |=> (resp_valid_o && resp_data_o == obc_reg);
    endproperty
    a_obc_query: assert property (p_obc_query) else $error("bad query answer");

    property p_break_no_make;
        @(posedge clock_i) disable iff (!rst_n_i)
            (state_reg == ST_BREAK) |-> (closed_reg & ~$past(closed_reg)) == '0;
    endproperty
    a_break_no_make: assert property (p_break_no_make) else $error("closed during break");

    property p_one_closed;
        @(posedge clock_i) disable iff (!rst_n_i)
            (one_reg && $past(one_reg) && $stable(one_reg)) |-> $countones(closed_reg) <= 1;
    endproperty
    a_one_closed: assert property (p_one_closed) else $error("two closed");

    property p_one_opens_all;
        @(posedge clock_i) disable iff (!rst_n_i)
            (state_reg == ST_IDLE && $rose(one_reg)) |-> closed_reg == '0;
    endproperty
    a_one_opens_all: assert property (p_one_opens_all) else $error("not all opened");

    property p_blocked_close_err;
        @(posedge clock_i) disable iff (!rst_n_i)
            (take && cmd_op_i == OP_CLOSE && ch_blocked) |=> (err_o && $stable(closed_reg));
    endproperty
    a_blocked_close_err: assert property (p_blocked_close_err) else $error("no error");

    property p_obc_set;
        @(posedge clock_i) disable iff (!rst_n_i)
            (take && cmd_op_i == OP_OBC_SET) |=> obc_reg == $past(cmd_bool_i);
    endproperty
    a_obc_set: assert property (p_obc_set) else $error("setting not taken");

endmodule : rcg_guard_seq

// File: verification/rcg_host_model.sv
// host side model: presents decoded commands and waits for acceptance
module rcg_host_model
    import rcg_pkg::*;
(
    // clock and handshake
    input wire logic clock_i,
    input wire logic ready_i,
    // command fields
    output logic valid_o,
    output rcg_op_e op_o,
    output logic matrix_o,
    output logic [1:0] a_slot_o,
    output logic [2:0] a_row_o,
    output logic [5:0] a_col_o,
    output logic range_o,
    output logic [1:0] b_slot_o,
    output logic [2:0] b_row_o,
    output logic [5:0] b_col_o,
    output logic [PAT_W-1:0] pat_o,
    output logic bool_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic lost = 1'b0;

    initial begin
        valid_o = 1'b0;
        op_o = OP_NOP;
        {matrix_o, a_slot_o, a_row_o, a_col_o, range_o} = '0;
        {b_slot_o, b_row_o, b_col_o, pat_o, bool_o} = '0;
    end

    // one command, held until the edge that sees ready high
    task automatic issue(input rcg_op_e op, input logic [1:0] as = 2'h1,
                         input logic [5:0] ac = 6'h01, input logic rng = 1'b0,
                         input logic [1:0] bs = 2'h1, input logic [5:0] bc = 6'h01,
                         input logic mtx = 1'b0, input logic [2:0] ar = 3'h1,
                         input logic [PAT_W-1:0] pat = 7'h00, input logic bv = 1'b0,
                         input logic [2:0] br = 3'h1);
        int n;
        @(posedge clock_i);
        #1;
        valid_o = 1'b1;
        op_o = op;
        matrix_o = mtx;
        {a_slot_o, a_row_o, a_col_o} = {as, ar, ac};
        {range_o, b_slot_o, b_row_o, b_col_o} = {rng, bs, br, bc};
        pat_o = pat;
        bool_o = bv;
        n = 0;
        while (ready_i !== 1'b1 && n < 400) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (n >= 400) lost = 1'b1;
        @(posedge clock_i);
        #1;
        valid_o = 1'b0;
        op_o = OP_NOP;
        // released slot, row, column and pattern fields do not keep their last value
        {a_slot_o, a_row_o, a_col_o, b_slot_o, b_row_o, b_col_o} =
            ~{a_slot_o, a_row_o, a_col_o, b_slot_o, b_row_o, b_col_o};
        pat_o = ~pat_o;
    endtask : issue
endmodule : rcg_host_model

// File: verification/rcg_guard_seq_bench.sv
// self-checking bench for the relay channel guard sequencer
module rcg_guard_seq_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rcg_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [NUM_CH-1:0] nv;
    logic [95:0] rnd;
    logic cmd_valid, cmd_matrix, cmd_range, cmd_bool;
    rcg_op_e cmd_op;
    logic [1:0] a_slot, b_slot;
    logic [2:0] a_row, b_row;
    logic [5:0] a_col, b_col;
    logic [PAT_W-1:0] cmd_pat;
    logic cmd_ready_o, resp_valid_o, resp_data_o, err_o, obc_o, one_closed_o;
    logic [NUM_CH-1:0] relay_closed_o, blocked_list_o, scan_list_o;
    logic [NUM_CH-1:0] exp, blk, stored;
    int errors = 0;
    int n_tests = 0;
    int n, c;

    always #2.5 clock = ~clock;

    rcg_host_model host (.clock_i(clock), .ready_i(cmd_ready_o), .valid_o(cmd_valid),
        .op_o(cmd_op), .matrix_o(cmd_matrix), .a_slot_o(a_slot), .a_row_o(a_row),
        .a_col_o(a_col), .range_o(cmd_range), .b_slot_o(b_slot), .b_row_o(b_row),
        .b_col_o(b_col), .pat_o(cmd_pat), .bool_o(cmd_bool));

    rcg_guard_seq uut (.clock_i(clock), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid),
        .cmd_op_i(cmd_op), .cmd_matrix_i(cmd_matrix), .a_slot_i(a_slot), .a_row_i(a_row),
        .a_col_i(a_col), .cmd_range_i(cmd_range), .b_slot_i(b_slot), .b_row_i(b_row),
        .b_col_i(b_col), .cmd_pat_i(cmd_pat), .cmd_bool_i(cmd_bool), .nv_list_i(nv),
        .cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
        .err_o(err_o), .relay_closed_o(relay_closed_o), .blocked_list_o(blocked_list_o),
        .scan_list_o(scan_list_o), .obc_o(obc_o), .one_closed_o(one_closed_o));

    function automatic logic [NUM_CH-1:0] chan(input int s, input int ch);
        return NUM_CH'(1) << ((s - 1) * SLOT_CH + ch - 1);
    endfunction : chan

    function automatic logic [NUM_CH-1:0] span(input int s, input int lo, input int hi);
        logic [NUM_CH-1:0] m;
        m = '0;
        for (int i = lo; i <= hi; i++) m |= chan(s, i);
        return m;
    endfunction : span

    task automatic check(input logic [NUM_CH-1:0] seen, input logic [NUM_CH-1:0] want,
                         input string what);
        n_tests++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test

    initial begin
        #(20000 * 5);
        errors++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h5cbe));
        rnd = {$urandom(), $urandom(), $urandom()};
        nv = rnd[NUM_CH-1:0];
        repeat (8) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(blocked_list_o, nv, "saved list not restored");
        check(NUM_CH'(obc_o), NUM_CH'(1), "open-before-close reset");
        for (int v = 0; v < 2; v++) begin
            host.issue(OP_OBC_SET, .bv(1'(v)));
            check(NUM_CH'(obc_o), NUM_CH'(v), "obc setting");
            host.issue(OP_OBC_QRY);
            check(NUM_CH'({resp_valid_o, resp_data_o}), NUM_CH'(2 + v), "obc query");
            host.issue(OP_ONE_SET, .bv(1'(v)));
            check(NUM_CH'(one_closed_o), NUM_CH'(v), "one-closed setting");
            host.issue(OP_ONE_QRY);
            check(NUM_CH'({resp_valid_o, resp_data_o}), NUM_CH'(2 + v), "one query");
        end
        host.issue(OP_ONE_SET);
        host.issue(OP_BLOCK_CLR);
        check(blocked_list_o, '0, "empty list");
        host.issue(OP_BLOCK_ADD, 2'h1, 6'h02, 1'b1, 2'h1, 6'h0A);
        host.issue(OP_BLOCK_ADD, 2'h2, 6'h06, .mtx(1'b1), .ar(3'h3));
        blk = span(1, 2, 10) | chan(2, 26);
        check(blocked_list_o, blk, "range and matrix entries");
        exp = '0;
        c = 2 + int'($urandom() % 9);
        host.issue(OP_CLOSE, 2'h1, 6'(c));
        check(NUM_CH'(err_o), NUM_CH'(1), "blocked close not flagged");
        check(relay_closed_o, exp, "blocked channel closed");
        repeat (5) begin
            c = 11 + int'($urandom() % 30);
            host.issue(OP_CLOSE, 2'h1, 6'(c));
            exp |= chan(1, c);
            check(relay_closed_o | NUM_CH'(err_o), exp, "free channel close");
        end
        stored = exp;
        host.issue(OP_PAT_STORE, .pat(7'h07));
        host.issue(OP_OPEN_ALL);
        host.issue(OP_BLOCK_PAT, .pat(7'h07));
        check(blocked_list_o, blk | stored, "pattern entry");
        host.issue(OP_BLOCK_CLR);
        host.issue(OP_SCAN_ADD, 2'h1, 6'h1E, 1'b1, 2'h1, 6'h23);
        check(scan_list_o, span(1, 30, 35), "scan list set");
        host.issue(OP_BLOCK_ADD, 2'h1, 6'h20);
        check(scan_list_o, '0, "scan list kept");
        host.issue(OP_OBC_SET, .bv(1'b1));
        host.issue(OP_CLOSE, 2'h2, 6'h01);
        host.issue(OP_CLOSE, 2'h2, 6'h02);
        check(relay_closed_o, chan(2, 1) | chan(2, 2), "two closed");
        host.issue(OP_ONE_SET, .bv(1'b1));
        check(relay_closed_o, '0, "mode entry opens all");
        host.issue(OP_CLOSE, 2'h2, 6'h03);
        host.issue(OP_CLOSE, 2'h2, 6'h04);
        check(relay_closed_o, '0, "old channel not opened first");
        check(NUM_CH'(cmd_ready_o), '0, "ready during break");
        n = 0;
        while (relay_closed_o === '0 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(NUM_CH'(n), NUM_CH'(BREAK_CYC), "break wait length");
        check(relay_closed_o, chan(2, 4), "one closed after break");
        host.issue(OP_OBC_SET);
        host.issue(OP_CLOSE, 2'h2, 6'h05);
        check(relay_closed_o, chan(2, 5), "direct swap");
        host.issue(OP_RESET);
        check(relay_closed_o | NUM_CH'({obc_o, one_closed_o}), NUM_CH'(2), "reset");
        check(blocked_list_o, chan(1, 32), "list kept over reset");
        host.issue(OP_CLOSE, 2'h2, 6'h07);
        host.issue(OP_CLOSE, 2'h2, 6'h08);
        host.issue(OP_PAT_STORE, .pat(7'h09));
        host.issue(OP_OPEN, 2'h2, 6'h07);
        check(relay_closed_o, chan(2, 8), "single open");
        host.issue(OP_RECALL, .pat(7'h09));
        check(relay_closed_o, chan(2, 7) | chan(2, 8), "pattern recall");
        host.issue(OP_ONE_SET, .bv(1'b1));
        host.issue(OP_RECALL, .pat(7'h09));
        check(relay_closed_o, chan(2, 7), "recall in one-closed mode");
        host.issue(OP_SCAN_ADD, 2'h2, 6'h01, 1'b1, 2'h2, 6'h03);
        check(scan_list_o, span(2, 1, 3), "scan list add");
        host.issue(OP_SCAN_CLR);
        check(scan_list_o, '0, "scan list clear");
        @(posedge clock);
        #1 rst_n = 1'b0;
        rnd = {$urandom(), $urandom(), $urandom()};
        nv = rnd[NUM_CH-1:0];
        repeat (3) @(posedge clock);
        #1 rst_n = 1'b1;
        @(posedge clock);
        #1;
        check(NUM_CH'(cmd_ready_o), '0, "ready before restore");
        check(blocked_list_o, nv, "saved list after second reset");
        host.issue(OP_BLOCK_CLR);
        host.issue(OP_BLOCK_ADD, 2'h1, 6'h09, 1'b1, 2'h1, 6'h02, .mtx(1'b1), .br(3'h2));
        check(blocked_list_o, span(1, 9, 12), "matrix range entry");
        check(NUM_CH'(host.lost), '0, "command never taken");
        finish_test();
    end
endmodule : rcg_guard_seq_bench
